// >>> src/rws_pkg.sv
// Shared constants, types and strap decoding for the reset, watchdog and strap logic
package rws_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int RST_MIN_NS = 100;
	localparam int RST_CAP_MIN_US = 100;
	localparam int WDOG_PULSE_MIN_MS = 1;
	localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CAP_MIN_CYC = (RST_CAP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WDOG_PULSE_CYC = (WDOG_PULSE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// Expiry period is not fixed by the part; plain default
	localparam int WDOG_TIMEOUT_CYC = 1000000;

	// ==========================================================
	// Strap fields and values
	localparam int STRAP_W = 3;
	localparam int STRAP_SERIAL_BIT = 2;
	localparam int STRAP_WIDTH_BIT = 1;
	localparam int STRAP_STROBE_BIT = 0;
	localparam logic [2:0] STRAP_RST_VAL = 3'h0;
	localparam logic [2:0] STRAP_SERIAL_CODE = 3'h4;

	// ==========================================================
	// Host port configuration
	typedef enum logic [1:0] {
		RWS_PORT_PARALLEL,
		RWS_PORT_SERIAL,
		RWS_PORT_RESERVED
	} rws_port_type;

	typedef struct packed {
		rws_port_type port;
		logic wide16;
		logic sep_strobes;
	} rws_cfg_type;

	localparam rws_cfg_type CFG_RST_VAL = '{RWS_PORT_PARALLEL, 1'b0, 1'b0};

	function automatic rws_cfg_type rws_decode(input logic [STRAP_W-1:0] code);
		rws_cfg_type c;
		c = CFG_RST_VAL;
		if (!code[STRAP_SERIAL_BIT]) begin
			c.port = RWS_PORT_PARALLEL;
			c.wide16 = code[STRAP_WIDTH_BIT];
			c.sep_strobes = code[STRAP_STROBE_BIT];
		end else if (code == STRAP_SERIAL_CODE) begin
			c.port = RWS_PORT_SERIAL;
		end else begin
			c.port = RWS_PORT_RESERVED;
		end
		return c;
	endfunction : rws_decode

endpackage : rws_pkg

// >>> src/rws_link_if.sv
// Board-level wires between the device end and the supervisor/host end
`timescale 1ns/1ns
interface rws_link_if;

	// ==========================================================
	// Drivers, low enable means driving
	logic host_rst_do;
	logic host_rst_oe_n;
	logic dev_rst_do;
	logic dev_rst_oe_n;
	logic watchdog_reset_out_n_do;
	logic watchdog_reset_out_n_oe_n;
	logic [rws_pkg::STRAP_W-1:0] host_if_select_straps;

	// ==========================================================
	// Resolved levels, both lines pulled up, watchdog line shorted to reset
	logic watchdog_reset_out_n;
	logic sys_rst_n;

	assign watchdog_reset_out_n = !(!watchdog_reset_out_n_oe_n && !watchdog_reset_out_n_do);
	assign sys_rst_n = !(!host_rst_oe_n && !host_rst_do) && !(!dev_rst_oe_n && !dev_rst_do)
		&& watchdog_reset_out_n; // [RULE6]

	modport dev (
		output dev_rst_do,
		output dev_rst_oe_n,
		output watchdog_reset_out_n_do,
		output watchdog_reset_out_n_oe_n,
		input sys_rst_n,
		input watchdog_reset_out_n,
		input host_if_select_straps
	);

	modport host (
		output host_rst_do,
		output host_rst_oe_n,
		output host_if_select_straps,
		input sys_rst_n,
		input watchdog_reset_out_n
	);

endinterface : rws_link_if

// >>> src/rws_dev_end.sv
// Device end: reset input, watchdog open-drain output and strap capture
`timescale 1ns/1ns
// Operation
// (RULE1) Reset low returns all logic to default; the watchdog pulse logic is reset only by srst_i, and the reset-cause flag survives a watchdog reset
// (RULE2) Supervisor holds reset low at least 100 ns
// (RULE3) With capacitor, reset low at least 100 us
// (RULE4) Watchdog output open-drain, low on expiry, power-on
// (RULE5) Watchdog low pulse lasts at least 1 ms
// (RULE6) Board shorts watchdog output to reset input
// (RULE7) Reset and watchdog pins undriven after reset
// (RULE8) Decode straps: parallel width/strobes, serial, reserved
// (RULE9) Hold reset until both supplies settle
// (RULE10) Unknown ramp order: hold both resets low
// (RULE11) Port acts as serial slave or parallel
// (RULE12) Straps sampled at reset release, kept
module rws_dev_end #(
	parameter int WDOG_TIMEOUT_CYC = rws_pkg::WDOG_TIMEOUT_CYC,
	parameter int WDOG_PULSE_CYC = rws_pkg::WDOG_PULSE_CYC
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic wdog_enable_i,
	input wire logic wdog_kick_i,
	output logic core_reset_o,
	output rws_pkg::rws_port_type host_port_o,
	output logic host_port_16bit_o,
	output logic host_port_sep_strobes_o,
	output logic host_cfg_valid_o,
	output logic wdog_pulse_active_o,
	output logic wdog_caused_reset_o,
	rws_link_if.dev link
);

	// ==========================================================
	// Sizes and checks
	localparam int TW = $clog2(WDOG_TIMEOUT_CYC + 1);
	localparam int PW = $clog2(WDOG_PULSE_CYC + 1);
	localparam logic [TW-1:0] TIMEOUT_LAST = TW'(WDOG_TIMEOUT_CYC - 1);
	localparam logic [PW-1:0] PULSE_LAST = PW'(WDOG_PULSE_CYC - 1);

	generate
		if (WDOG_TIMEOUT_CYC < 2) begin : g_bad_timeout
			$error("WDOG_TIMEOUT_CYC must be at least 2");
		end
		if (WDOG_PULSE_CYC < 1) begin : g_bad_pulse
			$error("WDOG_PULSE_CYC must be at least 1");
		end
	endgenerate

	// ==========================================================
	// Pin synchronisers
	logic rst_meta_ff;
	logic rst_sync_ff;
	logic [rws_pkg::STRAP_W-1:0] strap_meta_ff;
	logic [rws_pkg::STRAP_W-1:0] strap_sync_ff;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= link.sys_rst_n;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			strap_meta_ff <= rws_pkg::STRAP_RST_VAL;
			strap_sync_ff <= rws_pkg::STRAP_RST_VAL;
		end else begin
			strap_meta_ff <= link.host_if_select_straps;
			strap_sync_ff <= strap_meta_ff;
		end
	end

	// ==========================================================
	// Logic reset
	// No pulse filter: any sampled low resets; the supervisor keeps the minimum widths
	logic logic_rst;
	logic rst_prev_ff;
	logic core_reset_ff;
	logic release_evt;

	assign logic_rst = srst_i || !rst_sync_ff; // [RULE1] [RULE2] [RULE3]
	assign release_evt = rst_prev_ff && !logic_rst;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rst_prev_ff <= 1'b1;
		end else begin
			rst_prev_ff <= logic_rst;
		end
	end

	always_ff @(posedge clk_i) begin
		core_reset_ff <= logic_rst; // [RULE1]
	end

	// ==========================================================
	// Strap capture
	rws_pkg::rws_cfg_type cfg_ff;
	logic cfg_valid_ff;

	always_ff @(posedge clk_i) begin
		if (logic_rst) begin
			cfg_ff <= rws_pkg::CFG_RST_VAL; // [RULE1]
			cfg_valid_ff <= 1'b0;
		end else if (release_evt) begin
			cfg_ff <= rws_pkg::rws_decode(strap_sync_ff); // [RULE8] [RULE12]
			cfg_valid_ff <= 1'b1; // [RULE11]
		end
	end

	// ==========================================================
	// Watchdog timer
	logic [TW-1:0] timer_ff;
	logic expire_ff;

	always_ff @(posedge clk_i) begin
		if (logic_rst || !wdog_enable_i || wdog_kick_i) begin
			timer_ff <= '0;
		end else if (timer_ff == TIMEOUT_LAST) begin
			timer_ff <= '0;
		end else begin
			timer_ff <= timer_ff + TW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (logic_rst || !wdog_enable_i || wdog_kick_i) begin
			expire_ff <= 1'b0;
		end else begin
			expire_ff <= (timer_ff == TIMEOUT_LAST); // [RULE4]
		end
	end

	// ==========================================================
	// Watchdog pulse
	// Only power-on reset clears this part: with the pin shorted to reset the
	// pulse resets the device, and must not cut itself short
	typedef enum logic {
		PULSE_LOW,
		PULSE_RELEASED
	} rws_pulse_state_type;

	rws_pulse_state_type pulse_state_ff;
	logic [PW-1:0] pulse_cnt_ff;
	logic wdog_drive_ff;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pulse_state_ff <= PULSE_LOW; // [RULE4]
			pulse_cnt_ff <= '0;
		end else begin
			unique case (pulse_state_ff)
				PULSE_LOW: begin
					if (pulse_cnt_ff == PULSE_LAST) begin
						pulse_state_ff <= PULSE_RELEASED; // [RULE5]
						pulse_cnt_ff <= '0;
					end else begin
						pulse_cnt_ff <= pulse_cnt_ff + PW'(1);
					end
				end
				PULSE_RELEASED: begin
					if (expire_ff) begin
						pulse_state_ff <= PULSE_LOW; // [RULE4]
						pulse_cnt_ff <= '0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wdog_drive_ff <= 1'b1; // [RULE4]
		end else if (pulse_state_ff == PULSE_LOW) begin
			wdog_drive_ff <= (pulse_cnt_ff != PULSE_LAST); // [RULE5]
		end else begin
			wdog_drive_ff <= expire_ff; // [RULE4]
		end
	end

	// ==========================================================
	// Cause of the last reset
	// Set on expiry; cleared by srst_i, or when a reset starts while the pulse is off.
	// Keyed on the start, since the synced pin stays low past the pulse's own end
	logic wdog_cause_ff;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wdog_cause_ff <= 1'b0;
		end else if (expire_ff) begin
			wdog_cause_ff <= 1'b1;
		end else if (logic_rst && !rst_prev_ff && !wdog_drive_ff) begin
			wdog_cause_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Pin drivers
	logic rst_pin_oe_n_ff;

	always_ff @(posedge clk_i) begin
		rst_pin_oe_n_ff <= 1'b1; // [RULE7]
	end

	assign link.dev_rst_do = 1'b0;
	assign link.dev_rst_oe_n = rst_pin_oe_n_ff; // [RULE7]
	assign link.watchdog_reset_out_n_do = 1'b0; // [RULE4]
	assign link.watchdog_reset_out_n_oe_n = !wdog_drive_ff; // [RULE6] [RULE7]

	// ==========================================================
	// Outputs
	assign core_reset_o = core_reset_ff;
	assign host_port_o = cfg_ff.port;
	assign host_port_16bit_o = cfg_ff.wide16;
	assign host_port_sep_strobes_o = cfg_ff.sep_strobes;
	assign host_cfg_valid_o = cfg_valid_ff;
	assign wdog_pulse_active_o = wdog_drive_ff;
	assign wdog_caused_reset_o = wdog_cause_ff;

endmodule : rws_dev_end

// >>> src/rws_host_end.sv
// Supervisor and host end: reset generation, straps, watchdog observation
`timescale 1ns/1ns
module rws_host_end #(
	parameter int RST_HOLD_CYC = rws_pkg::RST_MIN_CYC,
	parameter int CAP_HOLD_CYC = rws_pkg::RST_CAP_MIN_CYC,
	parameter bit CAP_FITTED = 1'b0
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic supplies_good_i,
	input wire logic reset_req_i,
	input wire logic [rws_pkg::STRAP_W-1:0] strap_code_i,
	output logic test_rst_n_o,
	output logic sys_in_reset_o,
	output logic wdog_seen_o,
	output rws_pkg::rws_port_type host_port_o,
	output logic host_port_16bit_o,
	output logic host_port_sep_strobes_o,
	output logic host_cfg_valid_o,
	rws_link_if.host link
);

	// ==========================================================
	// Sizes and checks
	localparam int HOLD = CAP_FITTED ? CAP_HOLD_CYC : RST_HOLD_CYC;
	localparam int CW = $clog2(HOLD + 1);
	localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD - 1);

	generate
		if (RST_HOLD_CYC < 1 || CAP_HOLD_CYC < 1) begin : g_bad_hold
			$error("Reset hold counts must be at least 1");
		end
	endgenerate

	// ==========================================================
	// Synchronisers
	logic pg_meta_ff;
	logic pg_sync_ff;
	logic rst_meta_ff;
	logic rst_sync_ff;
	logic rst_prev_ff;
	logic wd_meta_ff;
	logic wd_sync_ff;
	logic wd_prev_ff;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pg_meta_ff <= 1'b0;
			pg_sync_ff <= 1'b0;
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
			rst_prev_ff <= 1'b0;
			wd_meta_ff <= 1'b1;
			wd_sync_ff <= 1'b1;
			wd_prev_ff <= 1'b1;
		end else begin
			pg_meta_ff <= supplies_good_i;
			pg_sync_ff <= pg_meta_ff;
			rst_meta_ff <= link.sys_rst_n;
			rst_sync_ff <= rst_meta_ff;
			rst_prev_ff <= rst_sync_ff;
			wd_meta_ff <= link.watchdog_reset_out_n;
			wd_sync_ff <= wd_meta_ff;
			wd_prev_ff <= wd_sync_ff;
		end
	end

	// ==========================================================
	// Reset sequencer
	typedef enum logic [1:0] {
		HOLD_POWER,
		HOLD_MIN,
		RUN
	} rws_seq_state_type;

	rws_seq_state_type state_ff;
	logic [CW-1:0] cnt_ff;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_ff <= HOLD_POWER;
			cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				HOLD_POWER: begin
					cnt_ff <= '0;
					if (pg_sync_ff) begin
						state_ff <= HOLD_MIN; // [RULE9]
					end
				end
				HOLD_MIN: begin
					if (!pg_sync_ff) begin
						state_ff <= HOLD_POWER;
					end else if (cnt_ff == HOLD_LAST) begin
						state_ff <= RUN; // [RULE2] [RULE3]
					end else begin
						cnt_ff <= cnt_ff + CW'(1);
					end
				end
				RUN: begin
					cnt_ff <= '0;
					if (!pg_sync_ff) begin
						state_ff <= HOLD_POWER; // [RULE9]
					end else if (reset_req_i) begin
						state_ff <= HOLD_MIN;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Pin drivers and straps
	// Straps only follow the input while reset is driven, so they are steady at release
	logic rst_drive_ff;
	logic test_rst_n_ff;
	logic [rws_pkg::STRAP_W-1:0] strap_ff;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rst_drive_ff <= 1'b1;
			test_rst_n_ff <= 1'b0;
			strap_ff <= rws_pkg::STRAP_RST_VAL;
		end else begin
			rst_drive_ff <= (state_ff != RUN); // [RULE9]
			test_rst_n_ff <= (state_ff != HOLD_POWER); // [RULE10]
			if (state_ff != RUN) begin
				strap_ff <= strap_code_i;
			end
		end
	end

	assign link.host_rst_do = 1'b0;
	assign link.host_rst_oe_n = !rst_drive_ff;
	assign link.host_if_select_straps = strap_ff;

	// ==========================================================
	// Observed state and host port selection
	logic in_reset_ff;
	logic wd_seen_ff;
	rws_pkg::rws_cfg_type cfg_ff;
	logic cfg_valid_ff;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			in_reset_ff <= 1'b1;
			wd_seen_ff <= 1'b0;
			cfg_ff <= rws_pkg::CFG_RST_VAL;
			cfg_valid_ff <= 1'b0;
		end else begin
			in_reset_ff <= !rst_sync_ff;
			wd_seen_ff <= wd_prev_ff && !wd_sync_ff; // [RULE6]
			if (!rst_sync_ff) begin
				cfg_valid_ff <= 1'b0;
			end else if (!rst_prev_ff) begin
				cfg_ff <= rws_pkg::rws_decode(strap_ff); // [RULE8] [RULE11]
				cfg_valid_ff <= 1'b1;
			end
		end
	end

	assign test_rst_n_o = test_rst_n_ff;
	assign sys_in_reset_o = in_reset_ff;
	assign wdog_seen_o = wd_seen_ff;
	assign host_port_o = cfg_ff.port;
	assign host_port_16bit_o = cfg_ff.wide16;
	assign host_port_sep_strobes_o = cfg_ff.sep_strobes;
	assign host_cfg_valid_o = cfg_valid_ff;

endmodule : rws_host_end

// >>> tb/rws_link_checker.sv
// Checker for the reset, watchdog and strap wires between the two ends
`timescale 1ns/1ns
module rws_link_checker #(
	parameter int PULSE_CYC = 8,
	parameter int HOLD_CYC = 25
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic host_rst_oe_n,
	input wire logic dev_rst_oe_n,
	input wire logic watchdog_reset_out_n_do,
	input wire logic watchdog_reset_out_n_oe_n,
	input wire logic [rws_pkg::STRAP_W-1:0] host_if_select_straps,
	input wire logic watchdog_reset_out_n,
	input wire logic sys_rst_n
);
	// ==========
	// Low-time counters run through reset, so a power-on pulse counts whole
	int wlo_ff;
	int hlo_ff;
	always_ff @(posedge clk_i) wlo_ff <= watchdog_reset_out_n ? 0 : wlo_ff + 1;
	always_ff @(posedge clk_i) hlo_ff <= host_rst_oe_n ? 0 : hlo_ff + 1;

	// ==========
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence wdog_drop_s;
		$fell(watchdog_reset_out_n);
	endsequence
	sequence wdog_back_s;
		$rose(watchdog_reset_out_n);
	endsequence

	dev_pin_idle_a: assert property (dev_rst_oe_n)
		else $error("device drove its reset pin");
	wdog_od_a: assert property (!watchdog_reset_out_n_oe_n |-> !watchdog_reset_out_n_do)
		else $error("watchdog pin driven high");
	wdog_min_a: assert property (wdog_back_s |-> wlo_ff >= PULSE_CYC)
		else $error("watchdog pulse too short");
	wdog_max_a: assert property (wdog_drop_s |-> ##[8:40] watchdog_reset_out_n)
		else $error("watchdog pin never released");
	wdog_short_a: assert property (!watchdog_reset_out_n |-> !sys_rst_n)
		else $error("watchdog low but reset line high");
	wdog_por_a: assert property ($fell(srst_i) |-> !watchdog_reset_out_n_oe_n)
		else $error("no watchdog pulse at power-on");
	wdog_free_a: assert property ($fell(srst_i) |-> ##[1:20] watchdog_reset_out_n_oe_n)
		else $error("watchdog pin not left undriven");
	host_hold_a: assert property ($rose(host_rst_oe_n) |-> hlo_ff >= HOLD_CYC)
		else $error("reset pulse too short");
	strap_hold_a: assert property ($changed(host_if_select_straps) |->
		!$past(host_rst_oe_n) || !host_rst_oe_n) else $error("straps moved outside reset");
endmodule : rws_link_checker

// >>> tb/reset_watchdog_host_strap_ctrl_bench.sv
// Self-checking bench joining the device end and the host end
`timescale 1ns/1ns
module reset_watchdog_host_strap_ctrl_bench;
	// ==========
	// Stimulus and observed outputs
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic wdog_enable_i = 1'b0;
	logic wdog_kick_i = 1'b0;
	logic supplies_good_i = 1'b0;
	logic reset_req_i = 1'b0;
	logic [2:0] strap_code_i = 3'h0;
	rws_pkg::rws_port_type d_port;
	logic d_w16, d_sep, d_valid, d_core, d_wpa, d_wcr, h_trst, h_inrst;
	rws_pkg::rws_port_type h_port;
	logic h_w16, h_sep, h_valid, h_wseen;
	int wseen_n = 0;
	logic valid_q = 1'b0;
	int error_cnt = 0;
	int n_tests = 0;
	int seed = 6267;
	int cyc = 0;
	logic [4:0] exp_q[$];

	rws_link_if link ();

	rws_dev_end #(.WDOG_TIMEOUT_CYC(16), .WDOG_PULSE_CYC(8)) i_rws_dev_end (
		.clk_i(clk_i), .srst_i(srst_i), .wdog_enable_i(wdog_enable_i),
		.wdog_kick_i(wdog_kick_i), .core_reset_o(d_core), .host_port_o(d_port),
		.host_port_16bit_o(d_w16), .host_port_sep_strobes_o(d_sep),
		.host_cfg_valid_o(d_valid), .wdog_pulse_active_o(d_wpa),
		.wdog_caused_reset_o(d_wcr), .link(link.dev));

	rws_host_end #(.RST_HOLD_CYC(25), .CAP_HOLD_CYC(40), .CAP_FITTED(1'b0)) i_rws_host_end (
		.clk_i(clk_i), .srst_i(srst_i), .supplies_good_i(supplies_good_i),
		.reset_req_i(reset_req_i), .strap_code_i(strap_code_i), .test_rst_n_o(h_trst),
		.sys_in_reset_o(h_inrst), .wdog_seen_o(h_wseen), .host_port_o(h_port),
		.host_port_16bit_o(h_w16), .host_port_sep_strobes_o(h_sep),
		.host_cfg_valid_o(h_valid), .link(link.host));

	rws_link_checker #(.PULSE_CYC(8), .HOLD_CYC(25)) i_rws_link_checker (
		.clk_i(clk_i), .srst_i(srst_i), .host_rst_oe_n(link.host_rst_oe_n),
		.dev_rst_oe_n(link.dev_rst_oe_n), .watchdog_reset_out_n_do(link.watchdog_reset_out_n_do),
		.watchdog_reset_out_n_oe_n(link.watchdog_reset_out_n_oe_n),
		.host_if_select_straps(link.host_if_select_straps),
		.watchdog_reset_out_n(link.watchdog_reset_out_n), .sys_rst_n(link.sys_rst_n));

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	// ==========
	// Expected configuration, worked out independently of the design's decoder
	function automatic logic [4:0] exp_of(input logic c, input logic [2:0] s);
		rws_pkg::rws_port_type p;
		p = s[2] ? (s == 3'h4 ? rws_pkg::RWS_PORT_SERIAL : rws_pkg::RWS_PORT_RESERVED)
			: rws_pkg::RWS_PORT_PARALLEL;
		return {c, p, s[2] ? 2'h0 : s[1:0]};
	endfunction : exp_of

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	// Bounded wait; a hang here counts as a mismatch
	task automatic wait_lvl(ref logic sig, input logic lvl);
		int n;
		n = 0;
		while (sig !== lvl && n < 500) begin
			@(posedge clk_i);
			n++;
		end
		check({7'h0, n == 500}, 8'h0);
	endtask : wait_lvl

	task automatic host_reset(input logic [2:0] s);
		strap_code_i <= s;
		exp_q.push_back(exp_of(1'b0, s));
		reset_req_i <= 1'b1;
		@(posedge clk_i);
		reset_req_i <= 1'b0;
		wait_lvl(d_valid, 1'b0);
		wait_lvl(d_valid, 1'b1);
	endtask : host_reset

	// ==========
	// Watcher: each new configuration is compared with the oldest note
	always @(posedge clk_i) begin
		logic [4:0] e;
		valid_q <= d_valid;
		cyc <= cyc + 1;
		if (h_wseen === 1'b1) wseen_n++;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
		if (d_valid === 1'b1 && valid_q === 1'b0) begin
			if (exp_q.size() == 0) check(8'h1, 8'h0);
			else begin
				e = exp_q.pop_front();
				check({3'h0, d_wcr, d_port, d_w16, d_sep}, {3'h0, e});
				check({3'h0, h_valid, h_port, h_w16, h_sep}, {4'h1, e[3:0]});
			end
		end
	end

	initial begin
		logic [2:0] s;
		logic [4:0] e;
		int k;
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check({7'h0, h_trst}, 8'h0);
		check({6'h0, h_inrst, d_core}, 8'h3);
		exp_q.push_back(exp_of(1'b0, 3'h0));
		supplies_good_i <= 1'b1;
		wait_lvl(d_valid, 1'b1);
		check({6'h0, h_trst, link.watchdog_reset_out_n_oe_n}, 8'h3);
		check(8'(wseen_n), 8'h1);
		for (int i = 0; i < 8; i++) host_reset(3'(i));
		// Straps moved while running must not reach the decoded port
		repeat (3) begin
			s = 3'($random(seed));
			host_reset(s);
			strap_code_i <= ~s;
			repeat (10) @(posedge clk_i);
			e = exp_of(1'b0, s);
			check({3'h0, d_wcr, d_port, d_w16, d_sep}, {3'h0, e});
			check({4'h0, h_port, h_w16, h_sep}, {4'h0, e[3:0]});
		end
		// Kicks every 6 cycles keep a 16-cycle timer from expiring
		strap_code_i <= s;
		wdog_enable_i <= 1'b1;
		repeat (10) begin
			wdog_kick_i <= 1'b1;
			@(posedge clk_i);
			wdog_kick_i <= 1'b0;
			repeat (5) @(posedge clk_i);
		end
		check({7'h0, d_wpa}, 8'h0);
		exp_q.push_back(exp_of(1'b1, s));
		wait_lvl(d_wpa, 1'b1);
		wdog_enable_i <= 1'b0;
		k = 0;
		while (d_wpa === 1'b1 && k < 100) begin
			@(posedge clk_i);
			k++;
			if (k == 3) check({7'h0, d_core}, 8'h1);
		end
		check({7'h0, k >= 8}, 8'h1);
		wait_lvl(d_valid, 1'b1);
		host_reset(3'h4);
		repeat (5) @(posedge clk_i);
		check(8'(wseen_n), 8'h2);
		conclude();
	end
endmodule : reset_watchdog_host_strap_ctrl_bench
